// *** core/mbp_bus_pins.sv ***
/*
  pin sequencer for the shared memory and peripheral bus: sdram command
  strobes, device read/write strobes, byte strobes, sdram read capture on
  the feedback clock, and gp pin alternate functions for clock enable and
  cell bus phy addresses.
  assumes requests come from same-clock logic and the feedback clock runs
  freely as the looped-back copy of the buffered clock.
*/
`timescale 1ns/1ps
`default_nettype none

module mbp_bus_pins (
  // clocks and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sdram_feedback_clock,
  // transaction request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_is_sdram,
  input wire logic req_write,
  input wire logic [mbp_pkg::SEL_W-2:0] req_sdram_bank,
  input wire logic [mbp_pkg::LANES-1:0] req_byte_enable,
  input wire logic [mbp_pkg::DATA_W-1:0] req_wdata,
  // transaction answer
  output logic rsp_valid,
  output logic [mbp_pkg::DATA_W-1:0] rsp_rdata,
  // shared bus pins
  output logic bus_read_not_write,
  output logic device_output_enable_n,
  output logic [mbp_pkg::LANES-1:0] byte_strobe_n,
  output logic [mbp_pkg::SEL_W-1:0] sdram_select_n,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic sdram_write_enable_n,
  output logic sdram_clock_enable,
  output logic buffered_system_clock_out,
  input wire logic [mbp_pkg::DATA_W-1:0] shared_data_bus_in,
  output logic [mbp_pkg::DATA_W-1:0] shared_data_bus_out,
  output logic shared_data_bus_oe,
  // cell bus phy addressing
  input wire logic cell_level2_mode,
  input wire logic [mbp_pkg::CELL_W-1:0] cell_tx_addr_req,
  input wire logic [mbp_pkg::CELL_W-1:0] cell_rx_addr_req,
  output logic [mbp_pkg::CELL_W-1:0] cell_tx_phy_address,
  output logic [mbp_pkg::CELL_W-1:0] cell_rx_phy_address,
  // general purpose pins and their alternate functions
  input wire logic sdram_clock_enable_alt,
  input wire logic [mbp_pkg::GP_W-1:0] gpio_out,
  input wire logic [mbp_pkg::GP_W-1:0] gpio_oe,
  output logic [mbp_pkg::GP_W-1:0] general_purpose_pin_out,
  output logic [mbp_pkg::GP_W-1:0] general_purpose_pin_oe
);
  import mbp_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic pin_is_alt(input int idx, input logic cke_alt, input logic l2);
    logic sel;
    sel = 1'b0;
    if (idx == GP_CKE) begin
      sel = cke_alt;
    end else if (idx == GP_TXA0 || idx == GP_TXA1 || idx == GP_RXA0 || idx == GP_RXA1) begin
      sel = l2;
    end
    return sel;
  endfunction

  function automatic logic is_sdram_state(input mbp_state_t s);
    return (s == ST_SD_ACT) || (s == ST_SD_RCD) || (s == ST_SD_CMD) ||
           (s == ST_SD_CAS) || (s == ST_SD_FETCH);
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  mbp_state_t state_r;
  mbp_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic write_r;
  logic [SEL_W-2:0] bank_r;
  logic [LANES-1:0] lanes_r;
  logic [DATA_W-1:0] wdata_r;
  logic fetch_tog_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic fetch_done;
  logic [DATA_W-1:0] dev_s1_r;
  logic [DATA_W-1:0] dev_s2_r;
  logic req_s1_r;
  logic req_s2_r;
  logic fb_ack_r;
  logic [DATA_W-1:0] fb_data_r;
  logic [GP_W-1:0] alt_val;
  logic wr_now;
  logic [SEL_W-2:0] bank_now;

  // ---------------------------------------------------------------
  // clock out
  // ---------------------------------------------------------------
  // board delay and loop back are outside; here the clock is only buffered
  assign buffered_system_clock_out = clk;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  assign req_ready = (state_r == ST_IDLE);
  assign fetch_done = (ack_s2_r == fetch_tog_r);
  // first pin cycle is decoded before the request is latched, so it reads the request itself
  assign wr_now = (state_r == ST_IDLE) ? req_write : write_r;
  assign bank_now = (state_r == ST_IDLE) ? req_sdram_bank : bank_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (req_valid) state_nxt = req_is_sdram ? ST_SD_ACT : ST_DEV_SETUP;
      ST_SD_ACT: state_nxt = ST_SD_RCD;
      ST_SD_RCD: if (cnt_r == '0) state_nxt = ST_SD_CMD;
      ST_SD_CMD: state_nxt = write_r ? ST_DONE : ST_SD_CAS;
      ST_SD_CAS: if (cnt_r == '0) state_nxt = ST_SD_FETCH;
      ST_SD_FETCH: if (fetch_done) state_nxt = ST_DONE;
      ST_DEV_SETUP: if (cnt_r == '0) state_nxt = ST_DEV_STROBE;
      ST_DEV_STROBE: if (cnt_r == '0) state_nxt = ST_DEV_HOLD;
      ST_DEV_HOLD: if (cnt_r == '0) state_nxt = ST_DONE;
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // state, counter and latched request
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // each counted wait state runs cnt_r+1 cycles, ST_SD_FETCH waits for fetch_done instead; the count is loaded on entry
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      case (state_nxt)
        ST_SD_RCD: cnt_r <= RCD_CYC - 4'h1;
        ST_SD_CAS: cnt_r <= CAS_CYC - 4'h1;
        ST_DEV_SETUP: cnt_r <= SETUP_CYC - 4'h1;
        ST_DEV_STROBE: cnt_r <= STROBE_CYC - 4'h1;
        ST_DEV_HOLD: cnt_r <= HOLD_CYC - 4'h1;
        default: cnt_r <= '0;
      endcase
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_r <= 1'b0;
      bank_r <= '0;
      lanes_r <= '0;
      wdata_r <= DATA_IDLE;
    end else if (state_r == ST_IDLE && req_valid) begin
      write_r <= req_write;
      bank_r <= req_sdram_bank;
      lanes_r <= req_byte_enable;
      wdata_r <= req_wdata;
    end
  end

  // ---------------------------------------------------------------
  // bus pins, decoded from the next state so they line up with it
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_read_not_write <= 1'b1;
      device_output_enable_n <= 1'b1;
      byte_strobe_n <= STROBES_IDLE;
      sdram_select_n <= SELECTS_IDLE;
      row_strobe_n <= 1'b1;
      column_strobe_n <= 1'b1;
      sdram_write_enable_n <= 1'b1;
      shared_data_bus_out <= DATA_IDLE;
      shared_data_bus_oe <= 1'b0;
    end else begin
      // idle values first; states below pull single pins low
      bus_read_not_write <= 1'b1;
      device_output_enable_n <= 1'b1;
      byte_strobe_n <= STROBES_IDLE;
      sdram_select_n <= SELECTS_IDLE;
      row_strobe_n <= 1'b1;
      column_strobe_n <= 1'b1;
      sdram_write_enable_n <= 1'b1;
      shared_data_bus_out <= (state_r == ST_IDLE) ? req_wdata : wdata_r;
      shared_data_bus_oe <= 1'b0;
      if (state_nxt != ST_IDLE && state_nxt != ST_DONE) begin
        bus_read_not_write <= !wr_now;
      end
      if (is_sdram_state(state_nxt)) begin
        // only the addressed device sees its select
        sdram_select_n[bank_now] <= 1'b0;
      end
      case (state_nxt)
        ST_SD_ACT: row_strobe_n <= 1'b0;
        ST_SD_CMD: begin
          column_strobe_n <= 1'b0;
          sdram_write_enable_n <= !write_r;
          byte_strobe_n <= ~lanes_r;
          shared_data_bus_oe <= write_r;
        end
        ST_SD_CAS, ST_SD_FETCH: begin
          // masks stay open so the read word is driven until fetched
          byte_strobe_n <= ~lanes_r;
        end
        ST_DEV_SETUP, ST_DEV_HOLD: shared_data_bus_oe <= wr_now;
        ST_DEV_STROBE: begin
          device_output_enable_n <= write_r;
          byte_strobe_n <= write_r ? ~lanes_r : STROBES_IDLE;
          shared_data_bus_oe <= write_r;
        end
        default: shared_data_bus_oe <= 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // clock enable
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdram_clock_enable <= 1'b0;
    end else begin
      sdram_clock_enable <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // device read data: pin input, two flops before use
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dev_s1_r <= DATA_IDLE;
      dev_s2_r <= DATA_IDLE;
    end else begin
      dev_s1_r <= shared_data_bus_in;
      dev_s2_r <= dev_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // sdram read fetch: toggle handshake to the feedback clock domain
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_tog_r <= 1'b0;
    end else if (state_r == ST_SD_CAS && state_nxt == ST_SD_FETCH) begin
      fetch_tog_r <= !fetch_tog_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= fb_ack_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  // the word is taken only after the feedback side has acknowledged it,
  // so fb_data_r is steady when read here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_rdata <= DATA_IDLE;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= (state_nxt == ST_DONE);
      if (state_r == ST_SD_FETCH && fetch_done) begin
        rsp_rdata <= fb_data_r;
      end else if (state_r == ST_DEV_STROBE && cnt_r == '0 && !write_r) begin
        // synced word reflects the pins two cycles back, still in the strobe
        rsp_rdata <= dev_s2_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // feedback clock domain
  // ---------------------------------------------------------------
  always_ff @(posedge sdram_feedback_clock or negedge reset_n) begin
    if (!reset_n) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
    end else begin
      req_s1_r <= fetch_tog_r;
      req_s2_r <= req_s1_r;
    end
  end

  // limitation: relies on the sdram holding the word until the toggle lands
  always_ff @(posedge sdram_feedback_clock or negedge reset_n) begin
    if (!reset_n) begin
      fb_data_r <= DATA_IDLE;
      fb_ack_r <= 1'b0;
    end else if (req_s2_r != fb_ack_r) begin
      fb_data_r <= shared_data_bus_in;
      fb_ack_r <= req_s2_r;
    end
  end

  // ---------------------------------------------------------------
  // cell bus addresses and gp pin alternates
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cell_tx_phy_address <= '0;
      cell_rx_phy_address <= '0;
    end else if (cell_level2_mode) begin
      cell_tx_phy_address <= cell_tx_addr_req;
      cell_rx_phy_address <= cell_rx_addr_req;
    end
  end

  always_comb begin
    alt_val = '0;
    alt_val[GP_CKE] = sdram_clock_enable;
    alt_val[GP_TXA0] = cell_tx_phy_address[0];
    alt_val[GP_TXA1] = cell_tx_phy_address[1];
    alt_val[GP_RXA0] = cell_rx_phy_address[0];
    alt_val[GP_RXA1] = cell_rx_phy_address[1];
  end

  generate
    for (genvar i = 0; i < GP_W; i++) begin : g_pin
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          general_purpose_pin_out[i] <= 1'b0;
          general_purpose_pin_oe[i] <= 1'b0;
        end else if (pin_is_alt(i, sdram_clock_enable_alt, cell_level2_mode)) begin
          general_purpose_pin_out[i] <= alt_val[i];
          general_purpose_pin_oe[i] <= 1'b1;
        end else begin
          general_purpose_pin_out[i] <= gpio_out[i];
          general_purpose_pin_oe[i] <= gpio_oe[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// *** core/mbp_pkg.sv ***
/*
  constants, states and timing counts for the memory bus pin sequencer.
  assumes a 100 ns system clock and a free-running sdram feedback clock.
*/
`default_nettype none

package mbp_pkg;

  // ---------------------------------------------------------------
  // widths and pin positions
  // ---------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int SEL_W = 2;
  localparam int CELL_W = 2;
  localparam int GP_W = 32;
  localparam int CNT_W = 4;
  localparam int GP_CKE = 21;
  localparam int GP_TXA0 = 22;
  localparam int GP_TXA1 = 23;
  localparam int GP_RXA0 = 24;
  localparam int GP_RXA1 = 25;

  // ---------------------------------------------------------------
  // timing, in ns except the cas latency in cycles, and derived cycle counts
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_RCD_NS = 200;
  localparam int CAS_LATENCY = 2;
  localparam int T_DEV_SETUP_NS = 100;
  localparam int T_DEV_STROBE_NS = 300;
  localparam int T_DEV_HOLD_NS = 100;
  localparam logic [CNT_W-1:0] RCD_CYC = CNT_W'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CAS_CYC = CNT_W'(CAS_LATENCY);
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((T_DEV_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'((T_DEV_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'((T_DEV_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // reset values of the pins
  // ---------------------------------------------------------------
  localparam logic [LANES-1:0] STROBES_IDLE = 4'hf;
  localparam logic [SEL_W-1:0] SELECTS_IDLE = 2'h3;
  localparam logic [DATA_W-1:0] DATA_IDLE = 32'h0000_0000;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SD_ACT = 4'h1,
    ST_SD_RCD = 4'h2,
    ST_SD_CMD = 4'h3,
    ST_SD_CAS = 4'h4,
    ST_SD_FETCH = 4'h5,
    ST_DEV_SETUP = 4'h6,
    ST_DEV_STROBE = 4'h7,
    ST_DEV_HOLD = 4'h8,
    ST_DONE = 4'h9
  } mbp_state_t;

endpackage

`default_nettype wire

// *** verification/mbp_bus_checker.sv ***
/*
  concurrent checks on the pin sequencer ports.
  assumes one clock domain on clk for everything watched here.
*/
`timescale 1ns/1ps
`default_nettype none

module mbp_bus_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // request side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_is_sdram,
  input wire logic req_write,
  input wire logic [3:0] req_byte_enable,
  // pins
  input wire logic bus_read_not_write,
  input wire logic device_output_enable_n,
  input wire logic [3:0] byte_strobe_n,
  input wire logic [1:0] sdram_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic sdram_write_enable_n,
  input wire logic sdram_clock_enable,
  input wire logic cell_level2_mode,
  input wire logic [1:0] cell_tx_addr_req,
  input wire logic [1:0] cell_rx_addr_req,
  input wire logic [1:0] cell_tx_phy_address,
  input wire logic [1:0] cell_rx_phy_address
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic take = req_valid && req_ready;

  property p_dir; take |=> bus_read_not_write == !$past(req_write); endproperty
  a_dir: assert property (p_dir) else $error("direction wrong after request");
  property p_oe; !device_output_enable_n |-> bus_read_not_write && sdram_select_n == 2'h3; endproperty
  a_oe: assert property (p_oe) else $error("output enable outside device read");
  property p_lane; take && !req_is_sdram && req_write |-> ##2 byte_strobe_n == ~$past(req_byte_enable, 2);
  endproperty
  a_lane: assert property (p_lane) else $error("byte strobes differ from lanes");
  property p_sel; !row_strobe_n |-> $countones(~sdram_select_n) == 1; endproperty
  a_sel: assert property (p_sel) else $error("not exactly one sdram select");
  property p_row; take && !req_is_sdram |=> row_strobe_n [*5]; endproperty
  a_row: assert property (p_row) else $error("row strobe in device transaction");
  property p_col; !row_strobe_n |=> column_strobe_n [*2] ##1 !column_strobe_n; endproperty
  a_col: assert property (p_col) else $error("column strobe spacing wrong");
  property p_we; !sdram_write_enable_n |-> !column_strobe_n && !bus_read_not_write; endproperty
  a_we: assert property (p_we) else $error("sdram write enable outside write");
  property p_cke; $past(reset_n) |-> sdram_clock_enable; endproperty
  a_cke: assert property (p_cke) else $error("clock enable low");
  property p_txa; cell_level2_mode |=> cell_tx_phy_address == $past(cell_tx_addr_req); endproperty
  a_txa: assert property (p_txa) else $error("transmit address not followed");
  property p_rxa; cell_level2_mode |=> cell_rx_phy_address == $past(cell_rx_addr_req); endproperty
  a_rxa: assert property (p_rxa) else $error("receive address not followed");
  property p_idle; req_ready |-> &byte_strobe_n && &sdram_select_n && row_strobe_n && column_strobe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("strobe active while idle");

  c_sdw: cover property (take && req_is_sdram && req_write);
  c_sdr: cover property (take && req_is_sdram && !req_write);
  c_dev: cover property (take && !req_is_sdram);
endmodule

bind mbp_bus_pins mbp_bus_checker mbp_bus_checker_i (.*);

`default_nettype wire

// *** verification/mbp_mem_model.sv ***
/*
  far-side model: sdram and device answering reads on the data pins.
  assumes the bench loops the data pins back through this model.
*/
`timescale 1ns/1ps
`default_nettype none

module mbp_mem_model #(
  parameter logic [31:0] READ_WORD = 32'h5a3c_96e1
) (
  // pins from the device
  input wire logic clk,
  input wire logic device_output_enable_n,
  input wire logic [1:0] sdram_select_n,
  input wire logic column_strobe_n,
  input wire logic bus_read_not_write,
  // data back
  output logic [31:0] shared_data_bus_in
);
  // ---------------------------------------------------------------
  // drive only in the read window, else the inverse so stale data fails
  // ---------------------------------------------------------------
  logic cas_seen_r;
  always_ff @(posedge clk) cas_seen_r <= (sdram_select_n == 2'h3) ? 1'b0 : (cas_seen_r | !column_strobe_n);
  assign shared_data_bus_in = (!device_output_enable_n || (cas_seen_r && bus_read_not_write)) ?
      READ_WORD : ~READ_WORD;
endmodule

`default_nettype wire

// *** verification/memory_bus_pin_signalling_tb_top.sv ***
/*
  directed bench for the pin sequencer with the far-side model.
  assumes a free-running feedback clock unrelated to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module memory_bus_pin_signalling_tb_top;
  import mbp_pkg::*;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic clk = 0, reset_n = 0, sdram_feedback_clock = 0;
  logic req_valid = 0, req_is_sdram = 0, req_write = 0, cell_level2_mode = 0, sdram_clock_enable_alt = 0;
  logic [0:0] req_sdram_bank = 0;
  logic [3:0] req_byte_enable = 0;
  logic [31:0] req_wdata = 0, gpio_out = 0, gpio_oe = 0;
  logic [1:0] cell_tx_addr_req = 0, cell_rx_addr_req = 0;
  logic req_ready, rsp_valid, bus_read_not_write, device_output_enable_n, row_strobe_n, column_strobe_n;
  logic sdram_write_enable_n, sdram_clock_enable, buffered_system_clock_out, shared_data_bus_oe;
  logic [31:0] rsp_rdata, shared_data_bus_in, shared_data_bus_out, general_purpose_pin_out, general_purpose_pin_oe;
  logic [3:0] byte_strobe_n;
  logic [1:0] sdram_select_n, cell_tx_phy_address, cell_rx_phy_address;
  int fail_count = 0, n_tests = 0;
  logic [1:0] sel_a;
  logic [3:0] bs_a;
  logic row_m, col_m, we_m, oe_m, rnw_a, rnw_o, dq_o;
  logic [31:0] dq;
  localparam logic [31:0] RW = 32'h5a3c_96e1;

  mbp_bus_pins mbp_bus_pins_i (.*);
  mbp_mem_model #(.READ_WORD(RW)) mbp_mem_model_i (.*);

  initial forever #50 clk = ~clk;
  initial begin
    #17;
    forever #40 sdram_feedback_clock = ~sdram_feedback_clock;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one transfer, pins folded over its length for later comparison
  task automatic xfer(input logic sd, input logic wr, input logic bk, input logic [3:0] be, input logic [31:0] wd);
    int n;
    @(negedge clk);
    {req_is_sdram, req_write, req_sdram_bank, req_byte_enable, req_wdata} = {sd, wr, bk, be, wd};
    req_valid = 1;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 0;
    {sel_a, bs_a, row_m, col_m, we_m, oe_m, rnw_a, rnw_o, dq_o, dq} = {2'h3, 4'hf, 5'h1f, 2'h0, 32'h0};
    n = 0;
    while (rsp_valid !== 1'b1 && n < 40) begin
      sel_a &= sdram_select_n;
      bs_a &= byte_strobe_n;
      {row_m, col_m, we_m, oe_m} &= {row_strobe_n, column_strobe_n, sdram_write_enable_n, device_output_enable_n};
      rnw_a &= bus_read_not_write;
      rnw_o |= bus_read_not_write;
      dq_o |= shared_data_bus_oe;
      if (shared_data_bus_oe === 1'b1 && byte_strobe_n !== 4'hf) dq = shared_data_bus_out;
      @(negedge clk);
      n++;
    end
    chk("response", 1, (n < 40));
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_idle();
    chk("idle strobes", {4'hf, 2'h3, 4'hf}, {byte_strobe_n, sdram_select_n, row_strobe_n, column_strobe_n,
        sdram_write_enable_n, device_output_enable_n});
    chk("clock enable", 1, sdram_clock_enable);
    $display("idle test done");
  endtask

  task automatic t_sd_write(input logic bk, input logic [3:0] be);
    xfer(1, 1, bk, be, 32'hc0de_0001);
    chk("sd w select", {30'h0, ~(2'h1 << bk)}, sel_a);
    chk("sd w row col", 0, {row_m, col_m});
    chk("sd w enable", 0, we_m);
    chk("sd w mask", {~be}, bs_a);
    chk("sd w dir", 0, rnw_o);
    $display("sdram write test done");
  endtask

  task automatic t_sd_read();
    xfer(1, 0, 1, 4'h6, 32'h0);
    chk("sd r select", 2'h1, sel_a);
    chk("sd r enable", 1, we_m);
    chk("sd r mask", 4'h9, bs_a);
    chk("sd r dir", 1, rnw_a);
    chk("sd r data", RW, rsp_rdata);
    $display("sdram read test done");
  endtask

  task automatic t_dev_write();
    xfer(0, 1, 0, 4'h5, 32'h1234_abcd);
    chk("dev w quiet", {2'h3, 3'h7}, {sel_a, row_m, col_m, oe_m});
    chk("dev w lanes", 4'ha, bs_a);
    chk("dev w dir", 0, rnw_o);
    chk("dev w data", 32'h1234_abcd, dq);
    $display("device write test done");
  endtask

  task automatic t_dev_read();
    xfer(0, 0, 0, 4'hf, 32'h0);
    chk("dev r oe", 0, oe_m);
    chk("dev r lanes", 4'hf, bs_a);
    chk("dev r dir", 1, rnw_a);
    chk("dev r drive", 0, dq_o);
    chk("dev r data", RW, rsp_rdata);
    $display("device read test done");
  endtask

  task automatic t_cell();
    gpio_out = 32'h03c0_0000;
    gpio_oe = 32'h0000_0000;
    cell_level2_mode = 1;
    cell_tx_addr_req = 2'h2;
    cell_rx_addr_req = 2'h1;
    sdram_clock_enable_alt = 1;
    repeat (3) @(negedge clk);
    chk("tx address", 2'h2, cell_tx_phy_address);
    chk("rx address", 2'h1, cell_rx_phy_address);
    chk("gp alt out", 5'h0d, general_purpose_pin_out[25:21]);
    chk("gp alt oe", 5'h1f, general_purpose_pin_oe[25:21]);
    cell_level2_mode = 0;
    sdram_clock_enable_alt = 0;
    repeat (3) @(negedge clk);
    chk("gp primary", 5'h1e, general_purpose_pin_out[25:21]);
    chk("tx held", 2'h2, cell_tx_phy_address);
    $display("cell test done");
  endtask

  task automatic t_clk_out();
    @(posedge clk);
    #1 chk("clock out high", 1, buffered_system_clock_out);
    @(negedge clk);
    #1 chk("clock out low", 0, buffered_system_clock_out);
    $display("clock out test done");
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1;
    repeat (2) @(negedge clk);
    t_idle();
    t_sd_write(0, 4'h3);
    t_sd_write(1, 4'h8);
    t_sd_read();
    t_dev_write();
    t_dev_read();
    t_cell();
    t_clk_out();
    close_out();
  end

  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule

`default_nettype wire
